// file: verilog/ssr_pkg.sv
/*
 * Constants shared by the status and result register bank of the barometric
 * sensor: register offsets, field positions, widths and reset values.
 * Assumes an 8-bit register address space reached through the serial port engine.
 */
package ssr_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_FIFO_FILL_STATUS     = 8'h26;
	localparam logic [7:0] ADDR_SAMPLE_STATUS        = 8'h27;
	localparam logic [7:0] ADDR_PRESSURE_OUT_LOW     = 8'h28;
	localparam logic [7:0] ADDR_PRESSURE_OUT_MID     = 8'h29;
	localparam logic [7:0] ADDR_PRESSURE_OUT_HIGH    = 8'h2a;
	localparam logic [7:0] ADDR_TEMPERATURE_OUT_LOW  = 8'h2b;
	localparam logic [7:0] ADDR_TEMPERATURE_OUT_HIGH = 8'h2c;
	localparam logic [7:0] ADDR_FILTER_RESET_TRIGGER = 8'h33;

	// Field positions in the buffer status register.
	localparam int FIFO_WATERMARK_BIT = 7;
	localparam int FIFO_OVERWRITE_BIT = 6;
	localparam int FILL_LEVEL_W       = 6;

	// Field positions in the sample status register.
	localparam int TEMP_OVERWRITE_BIT = 5;
	localparam int PRESS_OVERWRITE_BIT = 4;
	localparam int TEMP_AVAILABLE_BIT = 1;
	localparam int PRESS_AVAILABLE_BIT = 0;

	// Fill level of a full sample buffer.
	localparam logic [5:0] FILL_LEVEL_FULL = 6'h20;
	localparam int         WATERMARK_W     = 5;

	// Result widths.
	localparam int PRESS_W = 24;
	localparam int TEMP_W  = 16;
	localparam int TRIM_W  = 16;

	// Layout of one conversion entry in the result FIFO.
	localparam int ENTRY_TEMP_LSB      = 0;
	localparam int ENTRY_PRESS_LSB     = 16;
	localparam int ENTRY_TEMP_NEW_BIT  = 40;
	localparam int ENTRY_PRESS_NEW_BIT = 41;
	localparam int ENTRY_W             = 42;

	// Result FIFO geometry.
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;

	// Reset values.
	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam logic [23:0] RESET_PRESS  = 24'h000000;
	localparam logic [15:0] RESET_TEMP   = 16'h0000;

endpackage : ssr_pkg

// file: verilog/ssr_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides and registered read data.
 * Assumes one clock and a synchronous active-high reset shared with its user.
 */
`timescale 1ns/1ns
module ssr_fifo #(
	parameter int WIDTH = 42,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             take_in;
	logic             move_out;

	assign take_in  = in_valid_i && in_ready_o;
	assign move_out = (count != '0) && (!out_valid_o || out_ready_i);

	always_comb begin
		next_count = count;
		if (take_in && !move_out) begin
			next_count = count + (AW+1)'(1);
		end else if (!take_in && move_out) begin
			next_count = count - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			count      <= '0;
			in_ready_o <= 1'b0;
		end else begin
			count      <= next_count;
			// Registered ready: full is judged on the count that the next cycle will see.
			in_ready_o <= next_count != (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
		end else if (take_in) begin
			wr_ptr <= wr_ptr + AW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (take_in) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_ptr      <= '0;
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else begin
			if (move_out) begin
				rd_ptr     <= rd_ptr + AW'(1);
				out_data_o <= mem[rd_ptr];
			end
			out_valid_o <= move_out || (out_valid_o && !out_ready_i);
		end
	end

endmodule : ssr_fifo

// file: verilog/ssr_regs.sv
/*
 * Read-side status and result register bank of a digital barometric sensor.
 * Assumes a serial port engine on the same clock that issues one-cycle read and
 * write strobes with an 8-bit address, a measurement front end that pushes
 * conversion entries, and a sample buffer that reports its fill level.
 */
`timescale 1ns/1ns

// Functional notes
// - Watermark flag bit 7 is one when fill level is at or above watermark.
// - Overwrite flag bit 6 is one only when buffer full and a sample overwritten.
// - Six-bit fill level reports unread samples, 000000 empty, 100000 for 32.
// - After an overwrite, status shows watermark set, overwrite set, level 100000.
// - Temperature overwrite bit 5 sets when an unread temperature is replaced.
// - Pressure overwrite bit 4 sets when an unread pressure is replaced.
// - Temperature available bit 1 sets on each new temperature result.
// - Pressure available bit 0 sets on each new pressure result.
// - Sample status is refreshed once per conversion period.
// - Pressure is 24-bit two's complement at 28h, 29h and 2Ah.
// - Pressure result is measured minus offset trim when all select bits are zero.
// - Temperature is 16-bit two's complement at 2Bh and 2Ch.
// - Reading 33h resets the pressure low-pass filter.
// - Offset trim is a 16-bit two's complement value from two bytes.
// - Watermark level comes from a five-bit field of the buffer control register.
module ssr_regs (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Register port from the serial engine.
	input  wire logic        reg_rd_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_addr_i,
	output logic [7:0]       reg_rdata_o,
	output logic             reg_rvalid_o,
	output logic             reg_write_refused_o,
	// Conversion entries from the measurement front end.
	input  wire logic        conv_valid_i,
	output logic             conv_ready_o,
	input  wire logic [23:0] conv_press_i,
	input  wire logic [15:0] conv_temp_i,
	input  wire logic        conv_press_new_i,
	input  wire logic        conv_temp_new_i,
	// Configuration held by neighbouring register logic.
	input  wire logic [15:0] press_offset_trim_i,
	input  wire logic        differential_select_i,
	input  wire logic        auto_zero_select_i,
	input  wire logic        auto_reference_select_i,
	input  wire logic [4:0]  watermark_level_i,
	// Sample buffer state.
	input  wire logic [5:0]  fifo_fill_level_i,
	input  wire logic        fifo_overwrite_i,
	// Low-pass filter reset strobe.
	output logic             filter_reset_o
);

	typedef enum logic [1:0] {
		SSR_IDLE,
		SSR_PRESS_BURST,
		SSR_TEMP_BURST
	} ssr_lock_type;

	ssr_lock_type                  lock_state;
	logic [ssr_pkg::ENTRY_W-1:0]   conv_entry;
	logic                          entry_valid;
	logic                          entry_ready;
	logic [ssr_pkg::ENTRY_W-1:0]   entry_data;
	logic                          entry_load;
	logic                          entry_press_new;
	logic                          entry_temp_new;
	logic [ssr_pkg::PRESS_W-1:0]   entry_press;
	logic [ssr_pkg::TEMP_W-1:0]    entry_temp;
	logic [ssr_pkg::PRESS_W-1:0]   trim_ext;
	logic [ssr_pkg::PRESS_W-1:0]   next_press;
	logic                          trim_active;
	logic [ssr_pkg::PRESS_W-1:0]   press_result;
	logic [ssr_pkg::TEMP_W-1:0]    temp_result;
	logic                          press_available;
	logic                          temp_available;
	logic                          press_overwrite;
	logic                          temp_overwrite;
	logic                          press_read;
	logic                          temp_read;
	logic                          buffer_full;
	logic                          buffer_overwrite;
	logic [7:0]                    fifo_fill_status;
	logic [7:0]                    sample_status;
	logic [7:0]                    next_rdata;
	logic                          result_read;
	logic                          watermark_reached;

	// Result byte decodes, shared by the burst lock and the flag clear.
	function automatic logic ssr_is_press(input logic [7:0] addr);
		ssr_is_press = addr >= ssr_pkg::ADDR_PRESSURE_OUT_LOW &&
				addr <= ssr_pkg::ADDR_PRESSURE_OUT_HIGH;
	endfunction : ssr_is_press

	function automatic logic ssr_is_temp(input logic [7:0] addr);
		ssr_is_temp = addr == ssr_pkg::ADDR_TEMPERATURE_OUT_LOW ||
				addr == ssr_pkg::ADDR_TEMPERATURE_OUT_HIGH;
	endfunction : ssr_is_temp

	// Tells whether an address belongs to this bank; used for reads and for writes.
	function automatic logic ssr_is_mapped(input logic [7:0] addr);
		ssr_is_mapped = (addr >= ssr_pkg::ADDR_FIFO_FILL_STATUS &&
				addr <= ssr_pkg::ADDR_TEMPERATURE_OUT_HIGH) ||
				addr == ssr_pkg::ADDR_FILTER_RESET_TRIGGER;
	endfunction : ssr_is_mapped

	assign conv_entry = {conv_press_new_i, conv_temp_new_i, conv_press_i, conv_temp_i};

	// Conversions queue here so that a burst read never sees a result change under it.
	ssr_fifo #(
		.WIDTH (ssr_pkg::ENTRY_W),
		.DEPTH (ssr_pkg::FIFO_DEPTH),
		.AW    (ssr_pkg::FIFO_AW)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (conv_valid_i),
		.in_ready_o  (conv_ready_o),
		.in_data_i   (conv_entry),
		.out_valid_o (entry_valid),
		.out_ready_i (entry_ready),
		.out_data_o  (entry_data)
	);

	assign entry_press_new = entry_data[ssr_pkg::ENTRY_PRESS_NEW_BIT];
	assign entry_temp_new  = entry_data[ssr_pkg::ENTRY_TEMP_NEW_BIT];
	assign entry_press     = entry_data[ssr_pkg::ENTRY_PRESS_LSB +: ssr_pkg::PRESS_W];
	assign entry_temp      = entry_data[ssr_pkg::ENTRY_TEMP_LSB +: ssr_pkg::TEMP_W];

	// A new entry is taken only between read bursts, and never in a cycle that reads a
	// result byte: that byte is captured from the old result, so a load there would tear
	// the burst that the read opens.
	assign result_read = press_read || temp_read;
	assign entry_ready = lock_state == SSR_IDLE && !result_read;
	assign entry_load  = entry_valid && entry_ready;

	assign press_read = reg_rd_i && ssr_is_press(reg_addr_i);
	assign temp_read  = reg_rd_i && ssr_is_temp(reg_addr_i);

	// The burst opens on any byte of a result below its top byte and closes on its top byte or on a read of any other address.
	// A host that opens a burst and never closes it stalls every load; the queue then
	// fills and refuses further conversions.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			lock_state <= SSR_IDLE;
		end else if (reg_rd_i) begin
			unique case (lock_state)
				SSR_IDLE: begin
					if (press_read && reg_addr_i != ssr_pkg::ADDR_PRESSURE_OUT_HIGH) begin
						lock_state <= SSR_PRESS_BURST;
					end else if (reg_addr_i == ssr_pkg::ADDR_TEMPERATURE_OUT_LOW) begin
						lock_state <= SSR_TEMP_BURST;
					end
				end
				SSR_PRESS_BURST: begin
					if (reg_addr_i == ssr_pkg::ADDR_PRESSURE_OUT_HIGH || !press_read) begin
						lock_state <= SSR_IDLE;
					end
				end
				SSR_TEMP_BURST: begin
					if (reg_addr_i == ssr_pkg::ADDR_TEMPERATURE_OUT_HIGH || !temp_read) begin
						lock_state <= SSR_IDLE;
					end
				end
				default: begin
					// An illegal code drops the burst rather than lock loads out.
					lock_state <= SSR_IDLE;
				end
			endcase
		end
	end

	// Offset trim is sign-extended to the pressure width before subtraction.
	assign trim_ext    = {{(ssr_pkg::PRESS_W-ssr_pkg::TRIM_W){press_offset_trim_i[15]}},
			press_offset_trim_i};
	// Reference and differential modes are handled elsewhere; they bypass the trim.
	assign trim_active = !differential_select_i && !auto_zero_select_i &&
			!auto_reference_select_i;
	assign next_press  = trim_active ? entry_press - trim_ext : entry_press;

	// All three pressure bytes load together from one entry.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			press_result <= ssr_pkg::RESET_PRESS;
		end else if (entry_load && entry_press_new) begin
			press_result <= next_press;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			temp_result <= ssr_pkg::RESET_TEMP;
		end else if (entry_load && entry_temp_new) begin
			temp_result <= entry_temp;
		end
	end

	// Any byte of a result clears both of its flags, so a host reads the status byte first.
	// Flags refresh once per conversion entry; a new result wins over a read.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			press_available <= 1'b0;
			press_overwrite <= 1'b0;
		end else if (entry_load && entry_press_new) begin
			press_available <= 1'b1;
			press_overwrite <= press_available;
		end else if (press_read) begin
			press_available <= 1'b0;
			press_overwrite <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			temp_available <= 1'b0;
			temp_overwrite <= 1'b0;
		end else if (entry_load && entry_temp_new) begin
			temp_available <= 1'b1;
			temp_overwrite <= temp_available;
		end else if (temp_read) begin
			temp_available <= 1'b0;
			temp_overwrite <= 1'b0;
		end
	end

	always_comb begin
		sample_status = ssr_pkg::RESET_BYTE;
		sample_status[ssr_pkg::TEMP_OVERWRITE_BIT]  = temp_overwrite;
		sample_status[ssr_pkg::PRESS_OVERWRITE_BIT] = press_overwrite;
		sample_status[ssr_pkg::TEMP_AVAILABLE_BIT]  = temp_available;
		sample_status[ssr_pkg::PRESS_AVAILABLE_BIT] = press_available;
	end

	// Overwrite only counts once the buffer is really full.
	assign buffer_full      = fifo_fill_level_i == ssr_pkg::FILL_LEVEL_FULL;
	assign buffer_overwrite = buffer_full && fifo_overwrite_i;

	// At-or-above is taken; the strictly-above reading was rejected.
	assign watermark_reached = fifo_fill_level_i >= {1'b0, watermark_level_i};

	always_comb begin
		fifo_fill_status = ssr_pkg::RESET_BYTE;
		if (buffer_overwrite) begin
			fifo_fill_status[ssr_pkg::FIFO_WATERMARK_BIT] = 1'b1;
			fifo_fill_status[ssr_pkg::FIFO_OVERWRITE_BIT] = 1'b1;
			fifo_fill_status[ssr_pkg::FILL_LEVEL_W-1:0]   = ssr_pkg::FILL_LEVEL_FULL;
		end else begin
			fifo_fill_status[ssr_pkg::FIFO_WATERMARK_BIT] = watermark_reached;
			fifo_fill_status[ssr_pkg::FILL_LEVEL_W-1:0]   = fifo_fill_level_i;
		end
	end

	always_comb begin
		next_rdata = ssr_pkg::RESET_BYTE;
		unique case (reg_addr_i)
			ssr_pkg::ADDR_FIFO_FILL_STATUS:     next_rdata = fifo_fill_status;
			ssr_pkg::ADDR_SAMPLE_STATUS:        next_rdata = sample_status;
			ssr_pkg::ADDR_PRESSURE_OUT_LOW:     next_rdata = press_result[7:0];
			ssr_pkg::ADDR_PRESSURE_OUT_MID:     next_rdata = press_result[15:8];
			ssr_pkg::ADDR_PRESSURE_OUT_HIGH:    next_rdata = press_result[23:16];
			ssr_pkg::ADDR_TEMPERATURE_OUT_LOW:  next_rdata = temp_result[7:0];
			ssr_pkg::ADDR_TEMPERATURE_OUT_HIGH: next_rdata = temp_result[15:8];
			default:                            next_rdata = ssr_pkg::RESET_BYTE;
		endcase
	end

	// Read data is answered one cycle after the strobe.
	// It holds between reads, so the serial engine may shift it out at its own pace.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o  <= ssr_pkg::RESET_BYTE;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i && ssr_is_mapped(reg_addr_i);
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// A write to any register of this bank is dropped and only flagged.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_write_refused_o <= 1'b0;
		end else begin
			reg_write_refused_o <= reg_wr_i && ssr_is_mapped(reg_addr_i);
		end
	end

	// The filter restarts from the read itself so the transient is skipped.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			filter_reset_o <= 1'b0;
		end else begin
			filter_reset_o <= reg_rd_i && reg_addr_i == ssr_pkg::ADDR_FILTER_RESET_TRIGGER;
		end
	end

endmodule : ssr_regs

// file: tb/ssr_props.sv
/*
 * Concurrent checks on the status and result register bank ports.
 * Assumes one clock and the bank's synchronous active-high reset.
 */
`timescale 1ns/1ns
module ssr_props (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       reg_rd_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       reg_rvalid_o,
	input wire logic       reg_write_refused_o,
	input wire logic       conv_valid_i,
	input wire logic       conv_ready_o,
	input wire logic [4:0] watermark_level_i,
	input wire logic [5:0] fifo_fill_level_i,
	input wire logic       fifo_overwrite_i,
	input wire logic       filter_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic       mapped;
	logic       rd26;
	logic       rd33;
	logic [7:0] exp_fill;
	always_comb begin
		mapped = (reg_addr_i >= 8'h26 && reg_addr_i <= 8'h2c) || reg_addr_i == 8'h33;
		rd26 = reg_rd_i && reg_addr_i == 8'h26;
		rd33 = reg_rd_i && reg_addr_i == 8'h33;
		// An overrun flag is meaningless unless the buffer is full.
		exp_fill = (fifo_fill_level_i == 6'h20 && fifo_overwrite_i) ? 8'he0 :
			{fifo_fill_level_i >= {1'b0, watermark_level_i}, 1'b0, fifo_fill_level_i};
	end
	AST_READ_ANSWERED: assert property (reg_rd_i && mapped |=> reg_rvalid_o)
		else $error("mapped read not answered");
	AST_UNMAPPED_QUIET: assert property (reg_rd_i && !mapped |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
		else $error("unmapped read answered");
	AST_RVALID_CAUSE: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("read valid without a read");
	AST_FILL_STATUS: assert property (rd26 |=> reg_rdata_o == $past(exp_fill))
		else $error("buffer status byte wrong");
	AST_STATUS_LAYOUT: assert property (reg_rd_i && reg_addr_i == 8'h27 |=> (reg_rdata_o & 8'hcc) == 8'h00)
		else $error("unused sample status bits set");
	AST_FILTER_PULSE: assert property (rd33 |=> filter_reset_o)
		else $error("filter reset missing");
	AST_FILTER_CAUSE: assert property (filter_reset_o |-> $past(rd33))
		else $error("filter reset without read");
	AST_WRITE_REFUSED: assert property (reg_wr_i && mapped |=> reg_write_refused_o)
		else $error("write not refused");
	AST_DATA_HOLDS: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	cover property (rd33 ##1 filter_reset_o);
	cover property (reg_write_refused_o);
	cover property (conv_valid_i && !conv_ready_o);
	cover property (rd26 ##1 reg_rdata_o == 8'he0);
endmodule : ssr_props

bind ssr_regs ssr_props ssr_props_inst (.clk_i, .reset_i, .reg_rd_i, .reg_wr_i, .reg_addr_i,
	.reg_rdata_o, .reg_rvalid_o, .reg_write_refused_o, .conv_valid_i, .conv_ready_o,
	.watermark_level_i, .fifo_fill_level_i, .fifo_overwrite_i, .filter_reset_o);

// file: tb/ssr_host.sv
/*
 * Host controller model issuing single-byte register reads and writes.
 * Assumes the bank answers on the clock edge that samples the strobe.
 */
`timescale 1ns/1ns
module ssr_host (
	input  wire logic       clk_i,
	output logic            rd_o,
	output logic            wr_o,
	output logic [7:0]      addr_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	input  wire logic       refused_i
);
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'hff;
	end
	// The idle address is inverted so a stale value never looks like a request.
	task automatic access(input logic w, input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_i);
		rd_o <= !w;
		wr_o <= w;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rdata_i;
		v = w ? refused_i : rvalid_i;
	endtask : access
	task automatic clear_filter(output logic [7:0] d, output logic v);
		access(1'b0, 8'h33, d, v);
	endtask : clear_filter
endmodule : ssr_host

// file: tb/testbench.sv
/*
 * Self-checking bench for the status and result register bank.
 * Assumes the host model drives the register port and the bench the rest.
 */
`timescale 1ns/1ns
module testbench;
	typedef struct packed {
		logic [23:0] press;
		logic [15:0] temp;
		logic [15:0] trim;
		logic [2:0]  sel;
		logic [5:0]  lvl;
		logic [4:0]  wm;
		logic        fifo_overwrite_flag;
		logic [7:0]  exp26;
	} ssr_row_type;
	ssr_row_type rows[6] = '{
		'{24'h400000, 16'h0a00, 16'h0010, 3'h0, 6'h00, 5'h01, 1'b0, 8'h00},
		'{24'h000005, 16'hff00, 16'h0010, 3'h0, 6'h01, 5'h01, 1'b0, 8'h81},
		'{24'h123456, 16'h8000, 16'hfff0, 3'h0, 6'h1f, 5'h1f, 1'b0, 8'h9f},
		'{24'h7fffff, 16'h1234, 16'h0100, 3'h1, 6'h20, 5'h00, 1'b0, 8'ha0},
		'{24'h800000, 16'h0001, 16'h0100, 3'h2, 6'h20, 5'h1f, 1'b1, 8'he0},
		'{24'h000100, 16'h7fff, 16'h0100, 3'h4, 6'h05, 5'h06, 1'b1, 8'h05}};
	ssr_row_type cur;
	logic        clk;
	logic        reset;
	logic        conv_valid;
	logic        pnew;
	logic        tnew;
	logic        rd;
	logic        wr;
	logic [7:0]  addr;
	logic [7:0]  rdata;
	logic        rvalid;
	logic        refused;
	logic        ready;
	logic        filt;
	logic [7:0]  d;
	logic        v;
	logic        ok;
	logic [23:0] e;
	int          n;
	int          error_cnt = 0;
	int          cmp_count = 0;
	ssr_regs ssr_regs_inst (.clk_i(clk), .reset_i(reset), .reg_rd_i(rd), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.reg_write_refused_o(refused), .conv_valid_i(conv_valid), .conv_ready_o(ready),
		.conv_press_i(cur.press), .conv_temp_i(cur.temp), .conv_press_new_i(pnew),
		.conv_temp_new_i(tnew), .press_offset_trim_i(cur.trim),
		.differential_select_i(cur.sel[0]), .auto_zero_select_i(cur.sel[1]),
		.auto_reference_select_i(cur.sel[2]), .watermark_level_i(cur.wm),
		.fifo_fill_level_i(cur.lvl), .fifo_overwrite_i(cur.fifo_overwrite_flag), .filter_reset_o(filt));
	ssr_host ssr_host_inst (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr),
		.rdata_i(rdata), .rvalid_i(rvalid), .refused_i(refused));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		logic       val;
		ssr_host_inst.access(1'b0, a, got, val);
		chk(got, exp);
	endtask : rd_chk
	// Waits at the falling edge so the ready seen is the one the next edge samples.
	task automatic push(input logic [23:0] p, output logic acc);
		int k;
		@(posedge clk);
		conv_valid <= 1'b1;
		cur.press <= p;
		k = 0;
		@(negedge clk);
		while (ready !== 1'b1 && k < 4) begin
			k++;
			@(negedge clk);
		end
		acc = ready;
		@(posedge clk);
		conv_valid <= 1'b0;
	endtask : push
	task automatic complete_run;
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		#2000000;
		error_cnt++;
		complete_run();
	end
	initial begin
		reset = 1'b1;
		conv_valid = 1'b0;
		pnew = 1'b1;
		tnew = 1'b1;
		cur = rows[0];
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		ssr_host_inst.clear_filter(d, v);
		chk(d, 8'h00);
		chk({7'h00, filt}, 8'h01);
		chk({7'h00, v}, 8'h01);
		for (int a = 8'h26; a <= 8'h2c; a++)
			rd_chk(8'(a), 8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cur <= rows[i];
			e = (rows[i].sel != 3'h0) ? rows[i].press :
				rows[i].press - {{8{rows[i].trim[15]}}, rows[i].trim};
			push(rows[i].press, ok);
			repeat (2) @(posedge clk);
			rd_chk(8'h27, 8'h03);
			rd_chk(8'h26, rows[i].exp26);
			for (int j = 0; j < 3; j++)
				rd_chk(8'(8'h28 + j), e[8*j+:8]);
			rd_chk(8'h2b, rows[i].temp[7:0]);
			rd_chk(8'h2c, rows[i].temp[15:8]);
			rd_chk(8'h27, 8'h00);
		end
		ssr_host_inst.access(1'b1, 8'h27, d, v);
		chk({7'h00, v}, 8'h01);
		rd_chk(8'h27, 8'h00);
		ssr_host_inst.access(1'b1, 8'h40, d, v);
		chk({7'h00, v}, 8'h00);
		ssr_host_inst.access(1'b0, 8'h30, d, v);
		chk({v, d[6:0]}, 8'h00);
		@(posedge clk);
		cur.sel <= 3'h7;
		rd_chk(8'h28, e[7:0]);
		n = 0;
		// The tenth offer finds the queue full: eight words wait, one sits in the output stage.
		for (int k = 0; k < 10; k++) begin
			push(24'h0a0b00 + 24'(k), ok);
			if (ok === 1'b1)
				n++;
		end
		chk(8'(n), 8'h09);
		@(negedge clk);
		chk({7'h00, ready}, 8'h00);
		rd_chk(8'h2a, e[23:16]);
		repeat (30) @(posedge clk);
		rd_chk(8'h27, 8'h33);
		rd_chk(8'h28, 8'h08);
		rd_chk(8'h2a, 8'h0a);
		@(posedge clk);
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd_chk(8'h2a, 8'h00);
		rd_chk(8'h27, 8'h00);
		// The first byte is read in the very cycle in which the entry would load.
		push(24'h345678, ok);
		for (int j = 0; j < 3; j++)
			rd_chk(8'(8'h28 + j), 8'h00);
		repeat (2) @(posedge clk);
		rd_chk(8'h2a, 8'h34);
		@(posedge clk);
		pnew <= 1'b0;
		push(24'h7f0000, ok);
		repeat (2) @(posedge clk);
		rd_chk(8'h27, 8'h22);
		rd_chk(8'h2a, 8'h34);
		rd_chk(8'h2c, 8'h7f);
		@(posedge clk);
		pnew <= 1'b1;
		tnew <= 1'b0;
		push(24'h7f0000, ok);
		repeat (2) @(posedge clk);
		rd_chk(8'h27, 8'h01);
		rd_chk(8'h2a, 8'h7f);
		complete_run();
	end
endmodule : testbench
